// File: rtl/dbw_pkg.sv
// Shared constants for the debug breakpoint and watch unit
package dbw_pkg;
	// Register offsets, as word indices on the register port
	localparam logic [7:0] OFF_READ_THREAD_SEL = 8'h13;
	localparam logic [7:0] OFF_READ_REG_SEL    = 8'h14;
	localparam logic [7:0] OFF_DEBUG_CAUSE     = 8'h15;
	localparam logic [7:0] OFF_EVENT_DATA      = 8'h16;
	localparam logic [7:0] OFF_STOP_VECTOR     = 8'h18;
	localparam logic [7:0] OFF_IRQ_STATUS      = 8'h1A;
	localparam logic [7:0] OFF_IRQ_MASK        = 8'h1B;
	localparam logic [7:0] OFF_SCRATCH         = 8'h20;
	localparam logic [7:0] OFF_IBRK_ADDR       = 8'h30;
	localparam logic [7:0] OFF_IBRK_CTRL       = 8'h40;
	localparam logic [7:0] OFF_DWATCH_A        = 8'h50;
	localparam logic [7:0] OFF_DWATCH_B        = 8'h60;
	localparam logic [7:0] OFF_DWATCH_CTRL     = 8'h70;
	localparam logic [7:0] OFF_RWATCH_MASK     = 8'h80;
	localparam logic [7:0] OFF_RWATCH_VALUE    = 8'h90;
	localparam logic [7:0] OFF_RWATCH_CTRL     = 8'h9C;

	// Unit and scratch counts
	localparam int NUM_UNITS   = 4;
	localparam int NUM_SCRATCH = 8;

	// Control register field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_COND_BIT   = 1;
	localparam int CTRL_LOAD_BIT   = 2;
	localparam int CTRL_MASK_LSB   = 16;

	// Debug cause field positions
	localparam int CAUSE_UNIT_LSB   = 16;
	localparam int CAUSE_THREAD_LSB = 8;

	// Cause codes
	localparam logic [2:0] CAUSE_NONE   = 3'h0;
	localparam logic [2:0] CAUSE_HOST   = 3'h1;
	localparam logic [2:0] CAUSE_CALL   = 3'h2;
	localparam logic [2:0] CAUSE_IBRK   = 3'h3;
	localparam logic [2:0] CAUSE_DWATCH = 3'h4;
	localparam logic [2:0] CAUSE_RWATCH = 3'h5;

	// Interrupt status bit positions
	localparam int IRQ_HOST_BIT   = 0;
	localparam int IRQ_CALL_BIT   = 1;
	localparam int IRQ_IBRK_BIT   = 2;
	localparam int IRQ_DWATCH_BIT = 3;
	localparam int IRQ_RWATCH_BIT = 4;
	localparam int IRQ_BITS       = 5;

	// Reset values
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// Run state of the unit
	typedef enum logic [1:0] {
		DBW_RUN   = 2'b01,
		DBW_DEBUG = 2'b10
	} dbw_state_t;
endpackage

// File: rtl/dbw_scratch_if.sv
`timescale 1ns/1ns
`default_nettype none
// Two access views of the shared scratch storage
interface dbw_scratch_if;
	logic [2:0]  a_addr;   // Register port view index
	logic        a_wr;     // Register port write
	logic [31:0] a_wdata;  // Register port write data
	logic [31:0] a_rdata;  // Register port read data
	logic [2:0]  b_addr;   // Configuration view index
	logic        b_wr;     // Configuration view write
	logic [31:0] b_wdata;  // Configuration view write data
	logic [31:0] b_rdata;  // Configuration view read data

	// Owner of the storage
	modport mem (input a_addr, a_wr, a_wdata, b_addr, b_wr, b_wdata,
		output a_rdata, b_rdata);
	// User of the storage
	modport user (output a_addr, a_wr, a_wdata, b_addr, b_wr, b_wdata,
		input a_rdata, b_rdata);
endinterface
`default_nettype wire

// File: rtl/dbw_scratch_mem.sv
`timescale 1ns/1ns
`default_nettype none
// Eight-word scratch store shared by both views
module dbw_scratch_mem #(
	parameter int DEPTH = dbw_pkg::NUM_SCRATCH
) (
	// Clock and reset
	input  wire logic   sys_clk,
	input  wire logic   rst,
	// Both access views
	dbw_scratch_if.mem  port
);
	logic [31:0] store [DEPTH];  // Shared words
	logic [31:0] a_q;            // Registered read, view A
	logic [31:0] b_q;            // Registered read, view B

	// Same word written by both at once: the register port wins
	wire b_blocked = port.a_wr && (port.a_addr == port.b_addr);

	// Storage words, one per entry
	for (genvar i = 0; i < DEPTH; i++) begin : g_word
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				store[i] <= dbw_pkg::RESET_WORD;
			end else if (port.a_wr && port.a_addr == 3'(i)) begin
				store[i] <= port.a_wdata;
			end else if (port.b_wr && !b_blocked && port.b_addr == 3'(i)) begin
				store[i] <= port.b_wdata;
			end
		end
	end

	// Registered read data for both views
	always_ff @(posedge sys_clk) begin
		a_q <= store[port.a_addr];
		b_q <= store[port.b_addr];
	end

	assign port.a_rdata = a_q;
	assign port.b_rdata = b_q;
endmodule // dbw_scratch_mem
`default_nettype wire

// File: rtl/dbw_unit.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - 8-bit thread select for register read
// - 5-bit register number for register read
// - Record 3-bit debug cause, resets zero
// - Record lowest triggering unit; zero otherwise
// - Record causing thread; zero for host
// - Capture address or resource id as data
// - Stop vector holds threads after debug
// - Eight scratch words shared by two views
// - Four instruction breakpoints compare program counter
// - Condition bit: equal or not equal
// - Per-thread enable mask, resets zero
// - Bit 0 enables unit, resets zero
// - Four data watchpoints, two address banks
// - Bit 1 combines A and B: AND/OR
// - Bit 2 lets loads trigger
// - Four resource watchpoints, mask and value
// - Resource control: mask, enable, equal/not-equal condition
module dbw_unit #(
	parameter int UNITS = dbw_pkg::NUM_UNITS
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Configuration view of the scratch words
	input  wire logic [2:0]  cfg_addr,
	input  wire logic [31:0] cfg_wdata,
	input  wire logic        cfg_wr,
	output logic      [31:0] cfg_rdata,
	// Debug requests
	input  wire logic        host_debug_req,
	input  wire logic        call_valid,
	input  wire logic [7:0]  call_thread,
	input  wire logic        debug_return,
	// Executing instruction
	input  wire logic        exec_valid,
	input  wire logic [7:0]  exec_thread,
	input  wire logic [31:0] exec_pc,
	// Memory access
	input  wire logic        mem_valid,
	input  wire logic        mem_load,
	input  wire logic [7:0]  mem_thread,
	input  wire logic [31:0] mem_addr,
	// Resource access
	input  wire logic        res_valid,
	input  wire logic [7:0]  res_thread,
	input  wire logic [31:0] res_id,
	// Outputs to the core
	output logic             debug_enter,
	output logic             in_debug,
	output logic      [7:0]  read_thread_index,
	output logic      [4:0]  read_register_index,
	output logic      [7:0]  thread_stop_vector,
	output logic             irq
);
	// Register file
	logic [7:0]  read_thread;             // Thread to read
	logic [4:0]  read_reg;                // Register to read
	logic [2:0]  cause;                   // Debug cause code
	logic [1:0]  cause_unit;              // Triggering unit index
	logic [7:0]  cause_thread;            // Triggering thread
	logic [31:0] event_data;              // Captured address or id
	logic [7:0]  stop_vec;                // Threads held after debug
	logic [4:0]  irq_status;              // Sticky event bits
	logic [4:0]  irq_mask;                // Event enables
	logic [31:0] ib_addr  [UNITS];        // Instruction break targets
	logic [31:0] ib_ctrl  [UNITS];        // Instruction break controls
	logic [31:0] dw_a     [UNITS];        // Watch first addresses
	logic [31:0] dw_b     [UNITS];        // Watch second addresses
	logic [31:0] dw_ctrl  [UNITS];        // Data watch controls
	logic [31:0] rw_mask  [UNITS];        // Resource masks
	logic [31:0] rw_value [UNITS];        // Resource values
	logic [31:0] rw_ctrl  [UNITS];        // Resource watch controls
	logic [31:0] rdata_q;                 // Registered read data
	logic        rd_scratch_q;            // Last read hit scratch
	dbw_pkg::dbw_state_t state;           // Run or debug
	dbw_pkg::dbw_state_t next_state;      // Next run state
	// Hits of each unit
	logic [UNITS-1:0] ib_hit, dw_hit, rw_hit;
	// Scratch storage views
	dbw_scratch_if scr ();
	// Address decode
	wire         sel_scratch = reg_addr[7:3] == dbw_pkg::OFF_SCRATCH[7:3];
	wire  [1:0]  unit_idx    = reg_addr[1:0];
	wire         unit_slot   = reg_addr[3:2] == 2'h0;
	wire  [3:0]  unit_bank   = reg_addr[7:4];
	wire         sel_ib_addr = unit_slot && unit_bank == dbw_pkg::OFF_IBRK_ADDR[7:4];
	wire         sel_ib_ctrl = unit_slot && unit_bank == dbw_pkg::OFF_IBRK_CTRL[7:4];
	wire         sel_dw_a    = unit_slot && unit_bank == dbw_pkg::OFF_DWATCH_A[7:4];
	wire         sel_dw_b    = unit_slot && unit_bank == dbw_pkg::OFF_DWATCH_B[7:4];
	wire         sel_dw_ctrl = unit_slot && unit_bank == dbw_pkg::OFF_DWATCH_CTRL[7:4];
	wire         sel_rw_mask = unit_slot && unit_bank == dbw_pkg::OFF_RWATCH_MASK[7:4];
	wire         sel_rw_val  = unit_slot && unit_bank == dbw_pkg::OFF_RWATCH_VALUE[7:4];
	wire         sel_rw_ctrl = reg_addr[7:2] == dbw_pkg::OFF_RWATCH_CTRL[7:2];
	// Control words keep only their defined bits
	wire  [31:0] ib_ctrl_w = reg_wdata & 32'h00FF_0003;
	wire  [31:0] dw_ctrl_w = reg_wdata & 32'h00FF_0007;
	wire  [31:0] rw_ctrl_w = reg_wdata & 32'h00FF_0003;
	// Scratch hookup: register port on view A, configuration on view B
	// shared scratch words
	assign scr.a_addr  = reg_addr[2:0];
	assign scr.a_wr    = reg_wr && sel_scratch;
	assign scr.a_wdata = reg_wdata;
	assign scr.b_addr  = cfg_addr;
	assign scr.b_wr    = cfg_wr;
	assign scr.b_wdata = cfg_wdata;
	assign cfg_rdata   = scr.b_rdata;

	dbw_scratch_mem #(
		.DEPTH (dbw_pkg::NUM_SCRATCH)
	) u_scratch (
		.sys_clk (sys_clk),
		.rst     (rst),
		.port    (scr.mem)
	);

	// Per-unit comparators and registers
	for (genvar i = 0; i < UNITS; i++) begin : g_unit
		localparam int CTRL_MASK_LSB = dbw_pkg::CTRL_MASK_LSB; // Thread mask position
		wire wr_here = reg_wr && unit_idx == 2'(i);
		// Thread may fire only if its mask bit is set; threads 8 and up never
		// per-thread mask
		wire ib_thr = exec_thread[7:3] == 5'h00 && ib_ctrl[i][CTRL_MASK_LSB + exec_thread[2:0]];
		wire dw_thr = mem_thread[7:3] == 5'h00 && dw_ctrl[i][CTRL_MASK_LSB + mem_thread[2:0]];
		wire rw_thr = res_thread[7:3] == 5'h00 && rw_ctrl[i][CTRL_MASK_LSB + res_thread[2:0]];
		wire ib_cmp = ib_ctrl[i][dbw_pkg::CTRL_COND_BIT] ? exec_pc != ib_addr[i]
			: exec_pc == ib_addr[i];
		wire dw_ca  = mem_addr >= dw_a[i];
		wire dw_cb  = mem_addr <= dw_b[i];
		wire dw_cmp = dw_ctrl[i][dbw_pkg::CTRL_COND_BIT] ? dw_ca || dw_cb : dw_ca && dw_cb;
		// loads only when allowed; stores always count
		wire dw_kind = !mem_load || dw_ctrl[i][dbw_pkg::CTRL_LOAD_BIT];
		wire rw_ca  = (res_id & rw_mask[i]) == rw_value[i];
		wire rw_cmp = rw_ctrl[i][dbw_pkg::CTRL_COND_BIT] ? !rw_ca : rw_ca;
		assign ib_hit[i] = exec_valid && ib_ctrl[i][dbw_pkg::CTRL_ENABLE_BIT] && ib_thr && ib_cmp;
		assign dw_hit[i] = mem_valid && dw_ctrl[i][dbw_pkg::CTRL_ENABLE_BIT] && dw_thr
			&& dw_kind && dw_cmp;
		assign rw_hit[i] = res_valid && rw_ctrl[i][dbw_pkg::CTRL_ENABLE_BIT] && rw_thr && rw_cmp;
		// Unit registers; controls reset so no unit fires until armed
		// two address banks
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				ib_addr[i]  <= dbw_pkg::RESET_WORD;
				ib_ctrl[i]  <= dbw_pkg::RESET_WORD;
				dw_a[i]     <= dbw_pkg::RESET_WORD;
				dw_b[i]     <= dbw_pkg::RESET_WORD;
				dw_ctrl[i]  <= dbw_pkg::RESET_WORD;
				rw_mask[i]  <= dbw_pkg::RESET_WORD;
				rw_value[i] <= dbw_pkg::RESET_WORD;
				rw_ctrl[i]  <= dbw_pkg::RESET_WORD;
			end else if (wr_here) begin
				if (sel_ib_addr) ib_addr[i] <= reg_wdata;
				if (sel_ib_ctrl) ib_ctrl[i] <= ib_ctrl_w;
				if (sel_dw_a) dw_a[i] <= reg_wdata;
				if (sel_dw_b) dw_b[i] <= reg_wdata;
				if (sel_dw_ctrl) dw_ctrl[i] <= dw_ctrl_w;
				if (sel_rw_mask) rw_mask[i] <= reg_wdata;
				if (sel_rw_val) rw_value[i] <= reg_wdata;
				if (sel_rw_ctrl) rw_ctrl[i] <= rw_ctrl_w;
			end
		end
	end

	// Lowest set index of a four-bit hit vector
	function automatic logic [1:0] lowest(input logic [3:0] v);
		logic [1:0] r;
		r = 2'h0;
		for (int k = 3; k >= 0; k--) begin
			if (v[k]) r = 2'(k);
		end
		return r;
	endfunction

	// Cause priority: lower cause code wins when several arrive together
	wire any_ib  = |ib_hit;
	wire any_dw  = |dw_hit;
	wire any_rw  = |rw_hit;
	wire trigger = host_debug_req || call_valid || any_ib || any_dw || any_rw;
	wire enter   = state == dbw_pkg::DBW_RUN && trigger;
	logic [2:0]  next_cause;         // Cause to record
	logic [1:0]  next_unit;          // Unit to record
	logic [7:0]  next_thread;        // Thread to record
	logic [4:0]  event_set;          // Status bit raised by entry
	// Select what a debug entry records
	always_comb begin
		next_cause  = dbw_pkg::CAUSE_RWATCH;
		next_unit   = lowest(4'(rw_hit));
		next_thread = res_thread;
		event_set   = 5'h10;
		if (host_debug_req) begin
			next_cause  = dbw_pkg::CAUSE_HOST;
			next_thread = 8'h00;
			next_unit   = 2'h0;
			event_set   = 5'h01;
		end else if (call_valid) begin
			next_cause  = dbw_pkg::CAUSE_CALL;
			next_unit   = 2'h0;
			next_thread = call_thread;
			event_set   = 5'h02;
		end else if (any_ib) begin
			next_cause  = dbw_pkg::CAUSE_IBRK;
			next_unit   = lowest(4'(ib_hit));
			next_thread = exec_thread;
			event_set   = 5'h04;
		end else if (any_dw) begin
			next_cause  = dbw_pkg::CAUSE_DWATCH;
			next_unit   = lowest(4'(dw_hit));
			next_thread = mem_thread;
			event_set   = 5'h08;
		end
	end

	// Run state: leaves debug only on return from the core
	always_comb begin
		next_state = state;
		unique case (state)
			dbw_pkg::DBW_RUN: begin
				if (trigger) next_state = dbw_pkg::DBW_DEBUG;
			end
			dbw_pkg::DBW_DEBUG: begin
				if (debug_return) next_state = dbw_pkg::DBW_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) state <= dbw_pkg::DBW_RUN;
		else state <= next_state;
	end

	// Plain register writes
	wire wr_thread = reg_wr && reg_addr == dbw_pkg::OFF_READ_THREAD_SEL;
	wire wr_reg    = reg_wr && reg_addr == dbw_pkg::OFF_READ_REG_SEL;
	wire wr_cause  = reg_wr && reg_addr == dbw_pkg::OFF_DEBUG_CAUSE;
	wire wr_data   = reg_wr && reg_addr == dbw_pkg::OFF_EVENT_DATA;
	wire wr_stop   = reg_wr && reg_addr == dbw_pkg::OFF_STOP_VECTOR;
	wire wr_status = reg_wr && reg_addr == dbw_pkg::OFF_IRQ_STATUS;
	wire wr_mask   = reg_wr && reg_addr == dbw_pkg::OFF_IRQ_MASK;

	// Operand registers for the register-read operation, and the stop vector
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			read_thread <= 8'h00;
			read_reg    <= 5'h00;
			stop_vec    <= 8'h00;
		end else begin
			if (wr_thread) read_thread <= reg_wdata[7:0];
			if (wr_reg) read_reg <= reg_wdata[4:0];
			if (wr_stop) stop_vec <= reg_wdata[7:0];
		end
	end

	// Entry record; a capture in the same cycle beats a software write
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cause        <= dbw_pkg::CAUSE_NONE;
			cause_unit   <= 2'h0;
			cause_thread <= 8'h00;
			event_data   <= dbw_pkg::RESET_WORD;
		end else if (enter) begin
			cause        <= next_cause;
			cause_unit   <= next_unit;
			cause_thread <= next_thread;
			if (next_cause == dbw_pkg::CAUSE_DWATCH) event_data <= mem_addr;
			else if (next_cause == dbw_pkg::CAUSE_RWATCH) event_data <= res_id;
		end else begin
			if (wr_cause) begin
				cause        <= reg_wdata[2:0];
				cause_thread <= reg_wdata[15:8];
				cause_unit   <= reg_wdata[17:16];
			end
			if (wr_data) event_data <= reg_wdata;
		end
	end

	// Sticky status: setting wins over a clear in the same cycle
	wire [4:0] status_clr = wr_status ? reg_wdata[4:0] : 5'h00;
	wire [4:0] status_set = enter ? event_set : 5'h00;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_status <= 5'h00;
			irq_mask   <= 5'h00;
		end else begin
			irq_status <= (irq_status & ~status_clr) | status_set;
			if (wr_mask) irq_mask <= reg_wdata[4:0];
		end
	end
	// Read selection
	logic [31:0] rd_word;
	logic [31:0] rd_unit;
	always_comb begin
		rd_unit = 32'h0000_0000;
		if (sel_ib_addr) rd_unit = ib_addr[unit_idx];
		if (sel_ib_ctrl) rd_unit = ib_ctrl[unit_idx];
		if (sel_dw_a) rd_unit = dw_a[unit_idx];
		if (sel_dw_b) rd_unit = dw_b[unit_idx];
		if (sel_dw_ctrl) rd_unit = dw_ctrl[unit_idx];
		if (sel_rw_mask) rd_unit = rw_mask[unit_idx];
		if (sel_rw_val) rd_unit = rw_value[unit_idx];
		if (sel_rw_ctrl) rd_unit = rw_ctrl[unit_idx];
	end

	// Reserved bits read zero; unmapped offsets read zero
	always_comb begin
		unique case (reg_addr)
			dbw_pkg::OFF_READ_THREAD_SEL: rd_word = {24'h000000, read_thread};
			dbw_pkg::OFF_READ_REG_SEL:    rd_word = {27'h0000000, read_reg};
			dbw_pkg::OFF_DEBUG_CAUSE:     rd_word = {14'h0000, cause_unit, cause_thread,
				5'h00, cause};
			dbw_pkg::OFF_EVENT_DATA:      rd_word = event_data;
			dbw_pkg::OFF_STOP_VECTOR:     rd_word = {24'h000000, stop_vec};
			dbw_pkg::OFF_IRQ_STATUS:      rd_word = {27'h0000000, irq_status};
			dbw_pkg::OFF_IRQ_MASK:        rd_word = {27'h0000000, irq_mask};
			default:                      rd_word = rd_unit;
		endcase
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_q      <= dbw_pkg::RESET_WORD;
			rd_scratch_q <= 1'b0;
		end else begin
			rdata_q      <= reg_rd ? rd_word : 32'h0000_0000;
			rd_scratch_q <= reg_rd && sel_scratch;
		end
	end

	assign reg_rdata = rd_scratch_q ? scr.a_rdata : rdata_q;

	// Core-facing outputs
	assign debug_enter         = enter;
	assign in_debug            = state == dbw_pkg::DBW_DEBUG;
	assign read_thread_index   = read_thread;
	assign read_register_index = read_reg;
	assign thread_stop_vector  = stop_vec;
	assign irq                 = |(irq_status & irq_mask);
endmodule // dbw_unit
`default_nettype wire

// File: verification/dbw_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// Core stand-in: the debug routine dwells, then returns
module dbw_core_model #(
	parameter int RET_WAIT = 16
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Debug handshake
	input  wire logic in_debug,
	output var  logic debug_return
);
	int unsigned dwell; // Cycles spent in debug
	// One-cycle return pulse; a larger RET_WAIT models slow software
	always_ff @(posedge sys_clk) begin
		if (rst || !in_debug) begin
			dwell <= 0;
			debug_return <= 1'b0;
		end else begin
			dwell <= dwell + 1;
			debug_return <= (dwell == RET_WAIT);
		end
	end
endmodule // dbw_core_model
`default_nettype wire

// File: verification/dbw_unit_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level properties of the debug unit
module dbw_unit_checker #(
	parameter int UNITS = 4
) (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Debug requests and state
	input wire logic        host_debug_req,
	input wire logic        call_valid,
	input wire logic        debug_return,
	input wire logic        debug_enter,
	input wire logic        in_debug,
	// Operand, stop and interrupt outputs
	input wire logic [7:0]  read_thread_index,
	input wire logic [4:0]  read_register_index,
	input wire logic [7:0]  thread_stop_vector,
	input wire logic        irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Decoded register strobes
	wire logic wr_thr  = reg_wr && reg_addr == dbw_pkg::OFF_READ_THREAD_SEL;
	wire logic wr_reg  = reg_wr && reg_addr == dbw_pkg::OFF_READ_REG_SEL;
	wire logic wr_stop = reg_wr && reg_addr == dbw_pkg::OFF_STOP_VECTOR;
	wire logic wr_mask = reg_wr && reg_addr == dbw_pkg::OFF_IRQ_MASK;

	thread_sel_a: assert property (wr_thr |=> read_thread_index == $past(reg_wdata[7:0]))
		else $error("thread select not taken");
	reg_sel_a: assert property (wr_reg |=> read_register_index == $past(reg_wdata[4:0]))
		else $error("register select not taken");
	stop_vector_a: assert property (wr_stop |=> thread_stop_vector == $past(reg_wdata[7:0]))
		else $error("stop vector not taken");
	thread_rsvd_a: assert property (reg_rd && reg_addr == 8'h13 |=> reg_rdata[31:8] == 24'h0)
		else $error("thread select reserved bits set");
	cause_rsvd_a: assert property (reg_rd && reg_addr == 8'h15 |=>
		reg_rdata[31:18] == 14'h0 && reg_rdata[7:3] == 5'h0) else $error("cause reserved bits set");
	host_entry_a: assert property (host_debug_req && !in_debug |-> debug_enter ##1 in_debug)
		else $error("host request did not enter debug");
	call_entry_a: assert property (call_valid && !in_debug |-> debug_enter ##1 in_debug)
		else $error("debug call did not enter debug");
	no_reentry_a: assert property (in_debug |-> !debug_enter)
		else $error("entry while already in debug");
	debug_hold_a: assert property (in_debug && !debug_return |=> in_debug)
		else $error("debug state dropped without return");
	return_exit_a: assert property (in_debug && debug_return |=> !in_debug)
		else $error("return did not leave debug");
	irq_masked_a: assert property (wr_mask && reg_wdata[4:0] == 5'h0 |=> !irq)
		else $error("interrupt high with all sources masked");
	// Main scenarios reached
	cover property (host_debug_req && !in_debug);
	cover property (in_debug && debug_return);
	cover property (irq);
endmodule // dbw_unit_checker
bind dbw_unit dbw_unit_checker #(.UNITS(UNITS)) i_checker (.sys_clk(sys_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .host_debug_req(host_debug_req), .call_valid(call_valid),
	.debug_return(debug_return), .debug_enter(debug_enter), .in_debug(in_debug),
	.read_thread_index(read_thread_index), .read_register_index(read_register_index),
	.thread_stop_vector(thread_stop_vector), .irq(irq));
`default_nettype wire

// File: verification/tb_debug_breakpoint_watch_unit.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the debug unit
module tb_debug_breakpoint_watch_unit;
	// Offset, value written, value read back
	typedef struct {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
	} dbw_row_t;
	logic        sys_clk, rst, reg_wr, reg_rd, cfg_wr, host_debug_req, call_valid;
	logic        debug_return, exec_valid, mem_valid, mem_load, res_valid;
	logic        debug_enter, in_debug, irq;
	logic [2:0]  cfg_addr;
	logic [4:0]  read_register_index;
	logic [7:0]  reg_addr, call_thread, exec_thread, mem_thread, res_thread;
	logic [7:0]  read_thread_index, thread_stop_vector;
	logic [31:0] reg_wdata, reg_rdata, cfg_wdata, cfg_rdata, exec_pc, mem_addr, res_id;
	int          mismatches, comparisons;
	dbw_row_t    rows [17] = '{'{8'h13, 32'hFFFFFFFF, 32'h000000FF},
		'{8'h14, 32'hFFFFFFFF, 32'h0000001F}, '{8'h15, 32'hFFFFFFFF, 32'h0003FF07},
		'{8'h16, 32'hA5A55A5A, 32'hA5A55A5A}, '{8'h18, 32'hFFFFFFA5, 32'h000000A5},
		'{8'h1B, 32'hFFFFFFFF, 32'h0000001F}, '{8'h20, 32'h01234567, 32'h01234567},
		'{8'h27, 32'h89ABCDEF, 32'h89ABCDEF}, '{8'h33, 32'hFEDCBA98, 32'hFEDCBA98},
		'{8'h43, 32'hFFFFFFFF, 32'h00FF0003}, '{8'h53, 32'h0000F000, 32'h0000F000},
		'{8'h63, 32'h00000100, 32'h00000100}, '{8'h73, 32'hFFFFFFFF, 32'h00FF0007},
		'{8'h83, 32'hFFFFFFFF, 32'hFFFFFFFF}, '{8'h93, 32'h5A5A5A5A, 32'h5A5A5A5A},
		'{8'h9F, 32'hFFFFFFFF, 32'h00FF0003}, '{8'h11, 32'hFFFFFFFF, 32'h00000000}};

	dbw_unit i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rdata(cfg_rdata),
		.host_debug_req(host_debug_req), .call_valid(call_valid),
		.call_thread(call_thread), .debug_return(debug_return), .exec_valid(exec_valid),
		.exec_thread(exec_thread), .exec_pc(exec_pc), .mem_valid(mem_valid),
		.mem_load(mem_load), .mem_thread(mem_thread), .mem_addr(mem_addr),
		.res_valid(res_valid), .res_thread(res_thread), .res_id(res_id),
		.debug_enter(debug_enter), .in_debug(in_debug), .read_thread_index(read_thread_index),
		.read_register_index(read_register_index), .thread_stop_vector(thread_stop_vector),
		.irq(irq));
	dbw_core_model #(.RET_WAIT(16)) i_core (.sys_clk(sys_clk), .rst(rst),
		.in_debug(in_debug), .debug_return(debug_return));

	// Free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (mismatches == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
	endtask

	// One-cycle strobes; a wait before each keeps strobes apart
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	// v: host, call, resource, memory, execute
	task automatic fire(input logic [4:0] v, input logic ld, input logic [7:0] th,
		input logic [31:0] a);
		@(posedge sys_clk);
		{host_debug_req, call_valid, res_valid, mem_valid, exec_valid} <= v;
		{exec_thread, mem_thread, res_thread, call_thread} <= {4{th}};
		{exec_pc, mem_addr, res_id} <= {3{a}};
		mem_load <= ld;
		@(posedge sys_clk);
		{host_debug_req, call_valid, res_valid, mem_valid, exec_valid} <= 5'h0;
		#1;
	endtask

	// Entry, capture, status and interrupt, then wait for the return
	task automatic hit(input logic [4:0] v, input logic ld, input logic [7:0] th,
		input logic [31:0] a, input logic [31:0] cause, input logic irq_on);
		fire(v, ld, th, a);
		chk(in_debug, 1'b1);
		rd(dbw_pkg::OFF_DEBUG_CAUSE, cause);
		if (cause[2:0] >= 3'h4)
			rd(dbw_pkg::OFF_EVENT_DATA, a);
		rd(dbw_pkg::OFF_IRQ_STATUS, 32'h1 << (cause[2:0] - 3'h1));
		chk(irq, irq_on);
		wr(dbw_pkg::OFF_IRQ_STATUS, 32'hFFFFFFFF);
		#1 chk(irq, 1'b0);
		repeat (40) if (in_debug) @(posedge sys_clk);
		#1 chk(in_debug, 1'b0);
	endtask

	// Watchdog well beyond the expected run
	initial begin
		repeat (4000) @(posedge sys_clk);
		mismatches++;
		print_verdict();
	end

	// Main sequence
	initial begin
		{reg_wr, reg_rd, cfg_wr, host_debug_req, call_valid, exec_valid} = 6'h0;
		{mem_valid, mem_load, res_valid, reg_addr, cfg_addr} = 14'h0;
		{reg_wdata, cfg_wdata, exec_pc, mem_addr, res_id} = 160'h0;
		{call_thread, exec_thread, mem_thread, res_thread} = 32'h0;
		do_reset();
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].rdata);
		end
		// Mid-run reset clears every register
		do_reset();
		foreach (rows[i])
			rd(rows[i].addr, 32'h0);
		// Instruction breakpoints 1 and 2 on one address
		wr(8'h1B, 32'h0000001F);
		wr(8'h31, 32'h00000100);
		wr(8'h41, 32'h00040001);
		wr(8'h32, 32'h00000100);
		wr(8'h42, 32'h00040001);
		fire(5'h01, 1'b0, 8'h03, 32'h00000100);
		chk(in_debug, 1'b0);
		hit(5'h01, 1'b0, 8'h02, 32'h00000100, 32'h00010203, 1'b1);
		// Not-equal condition
		wr(8'h30, 32'h00000200);
		wr(8'h40, 32'h00010003);
		fire(5'h01, 1'b0, 8'h00, 32'h00000200);
		chk(in_debug, 1'b0);
		hit(5'h01, 1'b0, 8'h00, 32'h00000204, 32'h00000003, 1'b1);
		// Data watchpoints: unit 0 range AND, unit 3 OR with loads
		wr(8'h50, 32'h00001000);
		wr(8'h60, 32'h00001FFF);
		wr(8'h70, 32'h00020001);
		wr(8'h53, 32'h0000F000);
		wr(8'h63, 32'h00000100);
		wr(8'h73, 32'h00020007);
		fire(5'h02, 1'b0, 8'h01, 32'h00002000);
		chk(in_debug, 1'b0);
		fire(5'h02, 1'b1, 8'h01, 32'h00001800);
		chk(in_debug, 1'b0);
		hit(5'h02, 1'b0, 8'h01, 32'h00001800, 32'h00000104, 1'b1);
		hit(5'h02, 1'b1, 8'h01, 32'h0000F800, 32'h00030104, 1'b1);
		// Resource watchpoint 2, thread 7
		wr(8'h82, 32'h0000FF00);
		wr(8'h92, 32'h00001200);
		wr(8'h9E, 32'h00800001);
		fire(5'h04, 1'b0, 8'h07, 32'h00AB13CD);
		chk(in_debug, 1'b0);
		hit(5'h04, 1'b0, 8'h07, 32'h00AB12CD, 32'h00020705, 1'b1);
		// Debug call, then host request with the interrupt masked
		hit(5'h08, 1'b0, 8'h06, 32'h0, 32'h00000602, 1'b1);
		wr(8'h1B, 32'h0);
		hit(5'h10, 1'b0, 8'h05, 32'h0, 32'h00000001, 1'b0);
		// Scratch words seen through both views
		@(posedge sys_clk);
		cfg_addr <= 3'h3;
		cfg_wdata <= 32'hC0FFEE01;
		cfg_wr <= 1'b1;
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
		rd(8'h23, 32'hC0FFEE01);
		wr(8'h25, 32'h5EED0025);
		cfg_addr <= 3'h5;
		repeat (2) @(posedge sys_clk);
		#1 chk(cfg_rdata, 32'h5EED0025);
		print_verdict();
	end
endmodule // tb_debug_breakpoint_watch_unit
`default_nettype wire
